/* File: include/port2_rx_consts.svh */
// Constants of the Port 2 receive qualifier and FIFO status block.
// Assumes one 20 MHz core clock and a 10 Mb/s line.
`ifndef PORT2_RX_CONSTS_SVH
`define PORT2_RX_CONSTS_SVH

// ==========================================================
// Register offsets, one register per printed address
`define ADDR_LEN_ERR_CNT 8'hd6
`define ADDR_GAP_ERR_CNT 8'hde
`define ADDR_RX_GAP 8'he5
`define ADDR_RX_MAX_LEN 8'he6
`define ADDR_RX_MIN_LEN 8'he7
`define ADDR_LO_FRAMES 8'he8
`define ADDR_HI_FRAMES 8'he9
`define ADDR_LO_HALFWORDS 8'hea
`define ADDR_HI_HALFWORDS 8'heb
`define ADDR_FWD_HALFWORDS 8'hec
`define ADDR_STAMP_A_HI 8'hf0
`define ADDR_STAMP_A_LO 8'hf1
`define ADDR_STAMP_B_HI 8'hf2
`define ADDR_STAMP_B_LO 8'hf3

// ==========================================================
// Reset values and field limits
`define RST_RX_GAP 6'h0a
`define RST_RX_MAX_LEN 16'h0618
`define RST_RX_MIN_LEN 16'h0040
`define GAP_SETTING_MAX 6'h3f
`define GAP_UNIT_SHIFT 3
`define GAP_COUNT_MAX 10'h3ff
`define LEN_COUNT_MAX 16'hffff

// ==========================================================
// Timing: one bit time at 10 Mb/s in core clock cycles
`define BIT_TIME_NS 100
`define CLK_PERIOD_NS 50
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: include/port2_rx_pkg.sv */
// Types shared by the Port 2 receive qualifier files.
// Assumes nothing of its surroundings.
package port2_rx_pkg;
    typedef enum logic {LINE_IDLE, LINE_FRAME} line_state_t;
    typedef logic [8:0] frame_count_t;
    typedef logic [13:0] halfword_count_t;
    typedef logic [63:0] stamp_t;
endpackage

/* File: rtl/rx_gap_check.sv */
// Receive interframe gap measurement for Port 2.
// Assumes rxDv is the receive data valid level of the internal MII, on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "port2_rx_consts.svh"

module rx_gap_check
    import port2_rx_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Line and setting
    input wire logic rxDv,
    input wire logic [5:0] gapSetting,
    // Verdict for the frame in progress
    output logic gapBad_ff
);

    // ==========================================================
    // Bit time divider and gap counter
    line_state_t state_ff;
    logic [1:0] divCount_ff;
    logic bitTick;
    logic [9:0] gapBits_ff;
    logic [9:0] required;

    // The divider restarts while data is valid, so a gap is timed from its first idle cycle.
    // Waiting for the line state instead would lose one cycle and drop legal frames.
    assign bitTick = !rxDv && (divCount_ff == 2'(`BIT_CYCLES - 1));
    assign required = {4'h0, gapSetting} << `GAP_UNIT_SHIFT;

    // Divider for the bit time enable.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            divCount_ff <= 2'h0;
        else if (rxDv || bitTick)
            divCount_ff <= 2'h0;
        else
            divCount_ff <= divCount_ff + 2'h1;
    end

    // Line state follows the data valid level.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_ff <= LINE_IDLE;
        else
        begin
            case (state_ff)
                LINE_IDLE: if (rxDv) state_ff <= LINE_FRAME;
                LINE_FRAME: if (!rxDv) state_ff <= LINE_IDLE;
                default: state_ff <= LINE_IDLE;
            endcase
        end
    end

    // Idle bits are counted and saturate; the count starts full so the first frame passes.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            gapBits_ff <= `GAP_COUNT_MAX;
        else if (rxDv)
            gapBits_ff <= 10'h000;
        else if (bitTick && gapBits_ff != `GAP_COUNT_MAX)
            gapBits_ff <= gapBits_ff + 10'h001;
    end

    // The gap must be strictly larger than the setting times eight bit times.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            gapBad_ff <= 1'b0;
        else if (state_ff == LINE_IDLE && rxDv)
            gapBad_ff <= (gapBits_ff <= required);
    end

    // ==========================================================
    // Checks
    a_gap_verdict: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_ff == LINE_IDLE && rxDv) |=>
        gapBad_ff == ($past(gapBits_ff) <= ({4'h0, $past(gapSetting)} << 3)))
        else $error("Gap verdict does not match measured gap.");
    a_gap_counts_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_ff == LINE_IDLE && !rxDv && gapBits_ff < 10'h3f0 && divCount_ff == 2'h0)
        ##1 (!rxDv) |=> gapBits_ff == $past(gapBits_ff, 2) + 10'h001)
        else $error("Gap counter does not advance one per bit time.");

endmodule
`default_nettype wire

/* File: rtl/port2_rx_mac_fifo_status.sv */
// Port 2 receive frame qualifier, FIFO status and transmit stamp capture.
// Assumes MII receive strobes, FIFO levels and the time base all run on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "port2_rx_consts.svh"

module port2_rx_mac_fifo_status
    import port2_rx_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // MII receive side
    input wire logic rxDv,
    input wire logic rxByteStb,
    // Frame verdicts
    output logic rxFrameGood,
    output logic rxFrameDrop,
    output logic rxGapErrorFlag,
    output logic rxLengthError,
    // FIFO levels
    input wire logic [8:0] lowQueueFrameCount,
    input wire logic [8:0] highQueueFrameCount,
    input wire logic [13:0] lowQueueHalfwordCount,
    input wire logic [13:0] highQueueHalfwordCount,
    input wire logic [13:0] forwardQueueHalfwordCount,
    output logic rxFrameAvailable,
    // Transmit time stamp capture
    input wire logic [63:0] timeNow,
    input wire logic txStampStb,
    input wire logic txStampSlotB
);

    // ==========================================================
    // Helpers
    function automatic logic regHit(input logic en, input logic [7:0] a, input logic [7:0] r);
        return en && (a == r);
    endfunction

    // ==========================================================
    // Configuration registers
    logic [5:0] rxGapSetting_ff;
    logic [15:0] maxFrameBytes_ff;
    logic [15:0] minFrameBytes_ff;

    // Only the documented field bits are stored; the rest of a write is dropped.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxGapSetting_ff <= `RST_RX_GAP;
            maxFrameBytes_ff <= `RST_RX_MAX_LEN;
            minFrameBytes_ff <= `RST_RX_MIN_LEN;
        end
        else
        begin
            if (regHit(regWrEn, regAddr, `ADDR_RX_GAP))
                rxGapSetting_ff <= regWrData[5:0];
            if (regHit(regWrEn, regAddr, `ADDR_RX_MAX_LEN))
                maxFrameBytes_ff <= regWrData[15:0];
            if (regHit(regWrEn, regAddr, `ADDR_RX_MIN_LEN))
                minFrameBytes_ff <= regWrData[15:0];
        end
    end

    // ==========================================================
    // Receive frame qualification
    logic gapBad;
    logic dvPrev_ff;
    logic [15:0] byteCount_ff;
    logic frameEnd;
    logic lengthBad;

    rx_gap_check rx_gap_check_i (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .rxDv(rxDv),
        .gapSetting(rxGapSetting_ff),
        .gapBad_ff(gapBad)
    );

    assign frameEnd = dvPrev_ff && !rxDv;
    assign lengthBad = (byteCount_ff > maxFrameBytes_ff) || (byteCount_ff < minFrameBytes_ff);

    // Byte count of the frame in progress, saturating so a runaway frame stays long.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dvPrev_ff <= 1'b0;
            byteCount_ff <= 16'h0000;
        end
        else
        begin
            dvPrev_ff <= rxDv;
            if (rxDv && !dvPrev_ff)
                byteCount_ff <= {15'h0000, rxByteStb};
            else if (rxByteStb && byteCount_ff != `LEN_COUNT_MAX)
                byteCount_ff <= byteCount_ff + 16'h0001;
        end
    end

    // Verdict pulses at frame end; a gap error takes precedence over a length error.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxFrameGood <= 1'b0;
            rxFrameDrop <= 1'b0;
            rxGapErrorFlag <= 1'b0;
            rxLengthError <= 1'b0;
        end
        else
        begin
            rxFrameGood <= frameEnd && !gapBad && !lengthBad;
            rxFrameDrop <= frameEnd && (gapBad || lengthBad);
            rxGapErrorFlag <= frameEnd && gapBad;
            rxLengthError <= frameEnd && !gapBad && lengthBad;
        end
    end

    // ==========================================================
    // Error counters, wrapping at 32 bits
    logic [31:0] gapErrorCounter_ff;
    logic [31:0] lengthErrorCounter_ff;

    // Counters advance on the same edge as the verdict pulses.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gapErrorCounter_ff <= 32'h00000000;
            lengthErrorCounter_ff <= 32'h00000000;
        end
        else
        begin
            if (frameEnd && gapBad)
                gapErrorCounter_ff <= gapErrorCounter_ff + 32'h00000001;
            if (frameEnd && !gapBad && lengthBad)
                lengthErrorCounter_ff <= lengthErrorCounter_ff + 32'h00000001;
        end
    end

    // ==========================================================
    // FIFO status snapshot
    frame_count_t lowFrames_ff;
    frame_count_t highFrames_ff;
    halfword_count_t lowHalfwords_ff;
    halfword_count_t highHalfwords_ff;
    halfword_count_t fwdHalfwords_ff;

    // Levels are registered once so a read sees one consistent value.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lowFrames_ff <= 9'h000;
            highFrames_ff <= 9'h000;
            lowHalfwords_ff <= 14'h0000;
            highHalfwords_ff <= 14'h0000;
            fwdHalfwords_ff <= 14'h0000;
            rxFrameAvailable <= 1'b0;
        end
        else
        begin
            lowFrames_ff <= lowQueueFrameCount;
            highFrames_ff <= highQueueFrameCount;
            lowHalfwords_ff <= lowQueueHalfwordCount;
            highHalfwords_ff <= highQueueHalfwordCount;
            fwdHalfwords_ff <= forwardQueueHalfwordCount;
            rxFrameAvailable <= (lowQueueFrameCount != 9'h000)
                || (highQueueFrameCount != 9'h000);
        end
    end

    // ==========================================================
    // Transmit time stamp slots
    stamp_t stampA_ff;
    stamp_t stampB_ff;

    // The time base is latched when a stamped frame actually leaves the port.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stampA_ff <= 64'h0000000000000000;
            stampB_ff <= 64'h0000000000000000;
        end
        else if (txStampStb)
        begin
            if (txStampSlotB)
                stampB_ff <= timeNow;
            else
                stampA_ff <= timeNow;
        end
    end

    // ==========================================================
    // Register read port
    logic [31:0] readWord;

    // Read decode; reserved bits and unmapped offsets read as zero.
    always_comb
    begin
        case (regAddr)
            `ADDR_LEN_ERR_CNT: readWord = lengthErrorCounter_ff;
            `ADDR_GAP_ERR_CNT: readWord = gapErrorCounter_ff;
            `ADDR_RX_GAP: readWord = {26'h0000000, rxGapSetting_ff};
            `ADDR_RX_MAX_LEN: readWord = {16'h0000, maxFrameBytes_ff};
            `ADDR_RX_MIN_LEN: readWord = {16'h0000, minFrameBytes_ff};
            `ADDR_LO_FRAMES: readWord = {23'h000000, lowFrames_ff};
            `ADDR_HI_FRAMES: readWord = {23'h000000, highFrames_ff};
            `ADDR_LO_HALFWORDS: readWord = {18'h00000, lowHalfwords_ff};
            `ADDR_HI_HALFWORDS: readWord = {18'h00000, highHalfwords_ff};
            `ADDR_FWD_HALFWORDS: readWord = {18'h00000, fwdHalfwords_ff};
            `ADDR_STAMP_A_HI: readWord = stampA_ff[63:32];
            `ADDR_STAMP_A_LO: readWord = stampA_ff[31:0];
            `ADDR_STAMP_B_HI: readWord = stampB_ff[63:32];
            `ADDR_STAMP_B_LO: readWord = stampB_ff[31:0];
            default: readWord = 32'h00000000;
        endcase
    end

    // Read data is answered one cycle after the read strobe.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regRdData <= 32'h00000000;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (regRdEn)
                regRdData <= readWord;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_gap_drop_flag: assert property (
        frameEnd && gapBad |=> rxGapErrorFlag && rxFrameDrop && !rxFrameGood)
        else $error("Gap violation did not drop the frame.");
    a_length_drop: assert property (
        frameEnd && !gapBad && (byteCount_ff > maxFrameBytes_ff)
        |=> rxLengthError && rxFrameDrop && !rxFrameGood)
        else $error("Long frame was not dropped.");
    a_gap_err_count: assert property (
        rxGapErrorFlag |-> gapErrorCounter_ff == $past(gapErrorCounter_ff) + 32'h1)
        else $error("Gap error counter did not advance.");
    a_len_err_count: assert property (
        rxLengthError |-> lengthErrorCounter_ff == $past(lengthErrorCounter_ff) + 32'h1)
        else $error("Length error counter did not advance.");
    a_gap_setting_write: assert property (
        regWrEn && regAddr == `ADDR_RX_GAP |=> rxGapSetting_ff == $past(regWrData[5:0]))
        else $error("Gap setting write lost.");
    a_max_len_write: assert property (
        regWrEn && regAddr == 8'he6 |=> maxFrameBytes_ff == $past(regWrData[15:0]))
        else $error("Maximum length write lost.");
    a_min_len_write: assert property (
        regWrEn && regAddr == 8'he7 |=> minFrameBytes_ff == $past(regWrData[15:0]))
        else $error("Minimum length write lost.");
    a_low_frames_read: assert property (
        regRdEn && regAddr == 8'he8 |-> ##1 regRdValid
        ##0 regRdData == {23'h0, $past(lowQueueFrameCount, 2)})
        else $error("Low queue frame count read wrong.");
    a_high_halfword_read: assert property (
        regRdEn && regAddr == 8'heb |=> regRdData == {18'h0, $past(highQueueHalfwordCount, 2)})
        else $error("High queue half word read wrong.");
    a_stamp_capture: assert property (
        txStampStb && !txStampSlotB |=> stampA_ff == $past(timeNow))
        else $error("Stamp A did not hold the transmit time.");
    a_reserved_zero: assert property (
        regRdEn && regAddr == 8'he8 |=> regRdData[31:9] == 23'h0)
        else $error("Reserved bits read nonzero.");

    c_good_frame: cover property (frameEnd ##1 rxFrameGood);
    c_gap_drop: cover property (rxGapErrorFlag);
    c_length_drop: cover property (rxLengthError);
    c_stamp_b: cover property (txStampStb && txStampSlotB);

endmodule
`default_nettype wire

/* File: tb/phy_rx_model.sv */
// Behavioural Port 2 PHY that drives the internal MII receive strobes.
// Assumes its task is called from one bench process running on core_clk.
`timescale 1ns/100ps
`default_nettype none
module phy_rx_model
(
    // Clock
    input wire logic core_clk,
    // MII receive side
    output logic rxDv,
    output logic rxByteStb
);
    // ==========================================
    // Frame driver
    // The line starts idle, so the first frame sees a long quiet spell.
    initial
    begin
        rxDv = 1'b0;
        rxByteStb = 1'b0;
    end

    // Sends byteNum bytes, then holds the line low for lowNum cycles in all.
    task automatic sendFrame(input int byteNum, input int lowNum);
        repeat (byteNum)
        begin
            @(posedge core_clk);
            rxDv <= 1'b1;
            rxByteStb <= 1'b1;
        end
        @(posedge core_clk);
        rxDv <= 1'b0;
        rxByteStb <= 1'b0;
        repeat (lowNum - 1) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/port2_rx_mac_fifo_status_bench.sv */
// Self-checking bench for the Port 2 receive qualifier and status block.
// Assumes the design and the PHY model files are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "port2_rx_consts.svh"
module port2_rx_mac_fifo_status_bench import port2_rx_pkg::*;
;
    logic core_clk, reset_n, regWrEn, regRdEn, regRdValid;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, lfsrState, rdWord, v;
    logic rxDv, rxByteStb, rxFrameGood, rxFrameDrop, rxGapErrorFlag, rxLengthError;
    logic rxFrameAvailable, txStampStb, txStampSlotB;
    frame_count_t lowQueueFrameCount, highQueueFrameCount;
    halfword_count_t lowQueueHalfwordCount, highQueueHalfwordCount, forwardQueueHalfwordCount;
    stamp_t timeNow;
    stamp_t stampExp[2];
    logic [3:0] expQ[$];
    logic [7:0] roAddr[11] = '{8'he8, 8'he9, 8'hea, 8'heb, 8'hec, 8'hf0, 8'hf1, 8'hf2,
        8'hf3, 8'hd6, 8'hde};
    int gapList[4] = '{0, 1, 3, 63};
    int miscompares, samples_checked, gapSet, minLen, maxLen, prevLow, gapErrs, lenErrs, k, n;

    port2_rx_mac_fifo_status port2_rx_mac_fifo_status_i (.core_clk, .reset_n, .regAddr,
        .regWrEn, .regRdEn, .regWrData, .regRdData, .regRdValid, .rxDv, .rxByteStb,
        .rxFrameGood, .rxFrameDrop, .rxGapErrorFlag, .rxLengthError, .lowQueueFrameCount,
        .highQueueFrameCount, .lowQueueHalfwordCount, .highQueueHalfwordCount,
        .forwardQueueHalfwordCount, .rxFrameAvailable, .timeNow, .txStampStb, .txStampSlotB);
    phy_rx_model phy_rx_model_i (.core_clk, .rxDv, .rxByteStb);

    // ==========================================
    // Helpers
    // The clock runs at 20 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Steps the pseudo-random sequence.
    function automatic logic [31:0] rnd();
        lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
        return lfsrState;
    endfunction

    // Register write: one strobe cycle.
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask

    // Register read and compare, waiting a bounded time for the valid pulse.
    task automatic expectReg(input logic [7:0] a, input logic [31:0] want, input string what);
        int i;
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        for (i = 0; i < 4 && regRdValid !== 1'b1; i++)
        begin
            @(posedge core_clk);
            #1;
        end
        check("read valid", regRdValid, 1'b1);
        check(what, regRdData, want);
    endtask

    // Verdict {good, drop, gap flag, length error} worked out from gap and size.
    function automatic logic [3:0] expVerdict(input int lowBefore, input int bytes);
        if (lowBefore / 2 <= gapSet * 8)
            return 4'b0110;
        if (bytes > maxLen || bytes < minLen)
            return 4'b0101;
        return 4'b1000;
    endfunction

    // Queues the expected verdict, then has the PHY send the frame.
    task automatic frame(input int bytes, input int lowAfter);
        logic [3:0] e;
        e = expVerdict(prevLow, bytes);
        expQ.push_back(e);
        gapErrs += (e == 4'b0110);
        lenErrs += (e == 4'b0101);
        phy_rx_model_i.sendFrame(bytes, lowAfter);
        prevLow = lowAfter;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Each verdict pulse is matched against the oldest queued expectation.
    always @(negedge core_clk)
    begin
        if (reset_n && (rxFrameGood || rxFrameDrop || rxGapErrorFlag || rxLengthError))
        begin
            if (expQ.size() == 0)
                check("extra verdict", 1'b1, 1'b0);
            else
                check("verdict", {rxFrameGood, rxFrameDrop, rxGapErrorFlag, rxLengthError},
                    expQ.pop_front());
        end
    end

    // Cuts a hang short.
    initial
    begin
        repeat (80000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end

    // ==========================================
    // Tests
    initial
    begin
        {reset_n, regAddr, regWrEn, regRdEn, regWrData, txStampStb, txStampSlotB} = '0;
        {lowQueueFrameCount, highQueueFrameCount, timeNow} = '0;
        {lowQueueHalfwordCount, highQueueHalfwordCount, forwardQueueHalfwordCount} = '0;
        {miscompares, samples_checked, gapErrs, lenErrs} = '0;
        stampExp = '{64'h0, 64'h0};
        lfsrState = 32'h27a6;
        prevLow = 2000;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        expectReg(`ADDR_RX_GAP, 32'h0000000a, "gap reset");
        expectReg(`ADDR_RX_MAX_LEN, 32'h00000618, "max reset");
        expectReg(`ADDR_RX_MIN_LEN, 32'h00000040, "min reset");
        foreach (roAddr[i])
            expectReg(roAddr[i], 32'h0, "status reset");
        $display("test reset values done");
        regWrite(`ADDR_RX_GAP, 32'hffffffff);
        expectReg(`ADDR_RX_GAP, 32'h0000003f, "gap width");
        regWrite(`ADDR_RX_MAX_LEN, 32'hffffffff);
        expectReg(`ADDR_RX_MAX_LEN, 32'h0000ffff, "max width");
        regWrite(`ADDR_RX_MIN_LEN, 32'hffffffff);
        expectReg(`ADDR_RX_MIN_LEN, 32'h0000ffff, "min width");
        regWrite(`ADDR_LO_FRAMES, 32'h1ff);
        expectReg(`ADDR_LO_FRAMES, 32'h0, "ro write");
        regWrite(`ADDR_STAMP_B_LO, 32'h1234);
        expectReg(`ADDR_STAMP_B_LO, 32'h0, "ro stamp");
        regWrite(8'hf4, 32'h55);
        expectReg(8'hf4, 32'h0, "unmapped");
        $display("test register access done");
        for (k = 0; k < 6; k++)
        begin
            @(posedge core_clk);
            v = rnd();
            lowQueueFrameCount <= (k == 1) ? 9'h0 : v[8:0];
            highQueueFrameCount <= (k < 2) ? 9'h0 : v[17:9];
            lowQueueHalfwordCount <= v[31:18];
            v = rnd();
            highQueueHalfwordCount <= v[13:0];
            forwardQueueHalfwordCount <= v[27:14];
            repeat (3) @(posedge core_clk);
            #1;
            check("available", rxFrameAvailable, (lowQueueFrameCount != 0 ||
                highQueueFrameCount != 0));
            expectReg(`ADDR_LO_FRAMES, {23'h0, lowQueueFrameCount}, "lo frames");
            expectReg(`ADDR_HI_FRAMES, {23'h0, highQueueFrameCount}, "hi frames");
            expectReg(`ADDR_LO_HALFWORDS, {18'h0, lowQueueHalfwordCount}, "lo words");
            expectReg(`ADDR_HI_HALFWORDS, {18'h0, highQueueHalfwordCount}, "hi words");
            expectReg(`ADDR_FWD_HALFWORDS, {18'h0, forwardQueueHalfwordCount}, "fwd");
        end
        $display("test fifo levels done");
        for (k = 0; k < 4; k++)
        begin
            @(posedge core_clk);
            stampExp[k % 2] = {rnd(), rnd()};
            timeNow <= stampExp[k % 2];
            txStampStb <= 1'b1;
            txStampSlotB <= k[0];
            @(posedge core_clk);
            txStampStb <= 1'b0;
            timeNow <= {rnd(), rnd()};
            expectReg(`ADDR_STAMP_A_HI, stampExp[0][63:32], "stamp a hi");
            expectReg(`ADDR_STAMP_A_LO, stampExp[0][31:0], "stamp a lo");
            expectReg(`ADDR_STAMP_B_HI, stampExp[1][63:32], "stamp b hi");
            expectReg(`ADDR_STAMP_B_LO, stampExp[1][31:0], "stamp b lo");
        end
        $display("test stamps done");
        foreach (gapList[i])
        begin
            gapSet = gapList[i];
            minLen = 8 + int'(rnd() % 8);
            maxLen = minLen + 10 + int'(rnd() % 16);
            regWrite(`ADDR_RX_GAP, gapSet);
            regWrite(`ADDR_RX_MIN_LEN, minLen);
            regWrite(`ADDR_RX_MAX_LEN, maxLen);
            prevLow = 2000;
            frame(minLen, 16 * gapSet + 1);
            frame(minLen - 1, 16 * gapSet + 2);
            frame(maxLen, 1100);
            frame(maxLen + 1, 1100);
            frame(minLen - 1, 1);
            for (n = 0; n < 4; n++)
                frame(minLen - 2 + int'(rnd() % 20), 1 + int'(rnd() % (16 * gapSet + 8)));
            frame(minLen, 1100);
        end
        repeat (10) @(posedge core_clk);
        check("pending verdicts", expQ.size(), 0);
        expectReg(`ADDR_GAP_ERR_CNT, gapErrs, "gap errors");
        expectReg(`ADDR_LEN_ERR_CNT, lenErrs, "length errors");
        $display("test frames done");
        wrap_up();
    end
endmodule
`default_nettype wire
